// *** tc8_defs.svh ***
`ifndef TC8_DEFS_SVH
`define TC8_DEFS_SVH

// ****************************************************************
// counter limits
// ****************************************************************
`define TC_BOTTOM 8'h00
`define TC_MAX 8'hff
`define TC_ONE 8'h01

// ****************************************************************
// clock select and waveform mode codes
// ****************************************************************
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV32 3'h3
`define CS_DIV64 3'h4
`define CS_DIV128 3'h5
`define CS_DIV256 3'h6
`define CS_DIV1024 3'h7
`define WGM_NORMAL 2'h0
`define WGM_PWM_PC 2'h1
`define WGM_CTC 2'h2
`define WGM_PWM_FAST 2'h3

// ****************************************************************
// compare output actions
// ****************************************************************
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// ****************************************************************
// prescaler width and flag bit positions
// ****************************************************************
`define PRESC_W 10
`define FLAG_OVF 0
`define FLAG_CMP 1

`endif

// *** tc8_pkg.sv ***
package tc8_pkg;
    typedef struct packed {
        logic [2:0] clock_source_select;
        logic async_clock_select;
        logic [1:0] waveform_mode_bits;
        logic [1:0] compare_out_mode;
    } timer_control_t;

    typedef struct packed {
        logic compare_match_flag;
        logic overflow_flag;
    } timer_flags_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b00,
        DIR_DOWN = 2'b01
    } count_dir_t;
endpackage

// *** tc8_tick_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tc8_defs.svh"

module tc8_tick_gen
    import tc8_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] sel_i,
    input wire logic async_i,
    input wire logic osc_in_i,
    output logic tick_o
);
    logic [`PRESC_W-1:0] presc_q;
    logic osc_q;
    logic src_en;
    logic [`PRESC_W-1:0] presc_tap;

    // ****************************************************************
    // base clock: io clock, or crystal edges when async is selected
    // ****************************************************************
    // crystal pin is treated as synchronous; rising edge makes the tick
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            osc_q <= 1'b0;
        else
            osc_q <= osc_in_i;
    end

    always_comb
    begin
        src_en = async_i ? (osc_in_i & ~osc_q) : 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            presc_q <= '0;
        else if (sel_i == `CS_STOP)
            presc_q <= '0;
        else if (src_en)
            presc_q <= presc_q + `PRESC_W'(1);
    end

    // tick when all low bits of the prescaler are ones
    always_comb
    begin
        unique case (sel_i)
            `CS_DIV8: presc_tap = `PRESC_W'(7);
            `CS_DIV32: presc_tap = `PRESC_W'(31);
            `CS_DIV64: presc_tap = `PRESC_W'(63);
            `CS_DIV128: presc_tap = `PRESC_W'(127);
            `CS_DIV256: presc_tap = `PRESC_W'(255);
            `CS_DIV1024: presc_tap = `PRESC_W'(1023);
            default: presc_tap = '0;
        endcase
        tick_o = (sel_i != `CS_STOP) && src_en
            && ((presc_q & presc_tap) == presc_tap);
    end
endmodule // tc8_tick_gen

`default_nettype wire

// *** tc8_timer.sv ***
// Behaviour
// - counter and compare value are 8-bit, processor readable and writable
// - every interrupt request appears as a flag bit in the flag register
// - each request is gated by its own mask bit
// - clock select zero gives no ticks; counter holds
// - timer clock comes from the io clock by default
// - async select one takes the clock from the crystal pins
// - buffered compare value is compared with the counter always
// - a match sets the compare flag, requesting when masked in
// - match drives a waveform generator on the compare output pin
// - bottom is reached when the counter becomes 0x00
// - max is reached when the counter becomes 0xff
// - top is 0xff or the compare value, by mode
// - each tick clears, increments or decrements the counter
// - counter is accessible whether or not the clock runs
// - processor write to the counter beats clear or count
// - the two waveform mode bits set the counting sequence
// - overflow flag is set at the mode's defined point
// - top indication one clock after counter holds the sequence top
// - bottom indication one clock after counter is zero
// - normal mode counts up, overflow on the wrap to zero
// - clear-on-match mode zeroes the counter on compare equality
// - compare flag set on the tick after the match
// - a counter write blocks a match in the next tick
`timescale 1ns/10ps
`default_nettype none
`include "tc8_defs.svh"

module tc8_timer
    import tc8_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [WIDTH-1:0] CNT_WDATA_I,
    input wire logic CNT_WE_I,
    input wire logic [WIDTH-1:0] CMP_WDATA_I,
    input wire logic CMP_WE_I,
    input wire timer_control_t CTRL_WDATA_I,
    input wire logic CTRL_WE_I,
    input wire logic FORCE_CMP_I,
    input wire logic [1:0] MASK_WDATA_I,
    input wire logic MASK_WE_I,
    input wire logic [1:0] FLAG_CLR_I,
    input wire logic CRYSTAL_OSC_IN_I,
    output logic [WIDTH-1:0] COUNTER_VALUE_O,
    output logic [WIDTH-1:0] COMPARE_VALUE_REG_O,
    output timer_control_t TIMER_CONTROL_REG_O,
    output timer_flags_t TIMER_FLAG_REG_O,
    output logic [1:0] TIMER_MASK_REG_O,
    output logic OVF_IRQ_O,
    output logic CMP_IRQ_O,
    output logic COMPARE_OUTPUT_PIN_O,
    output logic TOP_O,
    output logic BOTTOM_O
);
    localparam logic [WIDTH-1:0] MAXV = WIDTH'(`TC_MAX);
    localparam logic [WIDTH-1:0] ZERO = WIDTH'(`TC_BOTTOM);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [WIDTH-1:0] cmp_buf_q;
    logic [WIDTH-1:0] cmp_q;
    timer_control_t ctrl_q;
    timer_flags_t flags_q;
    logic [1:0] mask_q;
    count_dir_t dir_q;
    count_dir_t dir_d;
    logic block_q;
    logic match_hit;
    logic oc_q;
    logic tick;
    logic match;
    logic at_top;
    logic at_bottom;
    logic ovf_set;
    logic [WIDTH-1:0] top_val;

    function automatic logic is_pwm(input logic [1:0] m);
        return (m == `WGM_PWM_PC) || (m == `WGM_PWM_FAST);
    endfunction

    // ****************************************************************
    // timer clock selection
    // ****************************************************************
    tc8_tick_gen u_tick (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .sel_i(ctrl_q.clock_source_select),
        .async_i(ctrl_q.async_clock_select),
        .osc_in_i(CRYSTAL_OSC_IN_I),
        .tick_o(tick)
    );

    // ****************************************************************
    // control, mask and compare registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            ctrl_q <= '0;
        else if (CTRL_WE_I)
            ctrl_q <= CTRL_WDATA_I;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            mask_q <= '0;
        else if (MASK_WE_I)
            mask_q <= MASK_WDATA_I;
    end

    // buffered in pwm modes so pulses never come out odd-length
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            cmp_buf_q <= '0;
        else if (CMP_WE_I)
            cmp_buf_q <= CMP_WDATA_I;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            cmp_q <= '0;
        else if (!is_pwm(ctrl_q.waveform_mode_bits))
            cmp_q <= CMP_WE_I ? CMP_WDATA_I : cmp_buf_q;
        else if (tick && (ctrl_q.waveform_mode_bits == `WGM_PWM_PC
                ? cnt_q == MAXV : cnt_q == ZERO))
            cmp_q <= cmp_buf_q;
    end

    // ****************************************************************
    // counter unit
    // ****************************************************************
    always_comb
    begin
        top_val = (ctrl_q.waveform_mode_bits == `WGM_CTC) ? cmp_q : MAXV;
        at_top = (cnt_q == top_val);
        at_bottom = (cnt_q == ZERO);
        match = (cnt_q == cmp_q);
        // the tick that ends the equal cycle is the one after the match
        match_hit = tick && match && !block_q && !CNT_WE_I;
        dir_d = dir_q;
        cnt_d = cnt_q;
        ovf_set = 1'b0;
        unique case (ctrl_q.waveform_mode_bits)
            `WGM_NORMAL:
            begin
                cnt_d = cnt_q + WIDTH'(`TC_ONE);
                ovf_set = (cnt_q == MAXV);
            end
            `WGM_CTC:
            begin
                cnt_d = match ? ZERO : cnt_q + WIDTH'(`TC_ONE);
                ovf_set = (cnt_q == MAXV);
            end
            `WGM_PWM_FAST:
            begin
                cnt_d = cnt_q + WIDTH'(`TC_ONE);
                ovf_set = (cnt_q == MAXV);
            end
            `WGM_PWM_PC:
            begin
                // turn at max and at bottom; overflow when bottom is hit
                if (dir_q == DIR_UP && cnt_q == MAXV)
                    dir_d = DIR_DOWN;
                else if (dir_q == DIR_DOWN && at_bottom)
                    dir_d = DIR_UP;
                cnt_d = (dir_d == DIR_UP) ? cnt_q + WIDTH'(`TC_ONE)
                                          : cnt_q - WIDTH'(`TC_ONE);
                ovf_set = at_bottom && dir_q == DIR_DOWN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            cnt_q <= '0;
        else if (CNT_WE_I)
            cnt_q <= CNT_WDATA_I;
        else if (tick)
            cnt_q <= cnt_d;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            dir_q <= DIR_UP;
        else if (ctrl_q.waveform_mode_bits != `WGM_PWM_PC)
            dir_q <= DIR_UP;
        else if (tick && !CNT_WE_I)
            dir_q <= dir_d;
    end

    // ****************************************************************
    // compare blocking and delayed flag setting
    // ****************************************************************
    // block lasts until one tick has passed, so it holds while stopped
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            block_q <= 1'b0;
        else if (CNT_WE_I)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    // set beats clear when both land in one cycle
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            flags_q <= '0;
        else
        begin
            flags_q.compare_match_flag <= match_hit
                || (flags_q.compare_match_flag
                && !FLAG_CLR_I[`FLAG_CMP]);
            flags_q.overflow_flag <= (tick && !CNT_WE_I && ovf_set)
                || (flags_q.overflow_flag
                && !FLAG_CLR_I[`FLAG_OVF]);
        end
    end

    // ****************************************************************
    // waveform generator
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            oc_q <= 1'b0;
        else if (!is_pwm(ctrl_q.waveform_mode_bits))
        begin
            if (match_hit || FORCE_CMP_I)
            begin
                unique case (ctrl_q.compare_out_mode)
                    `COM_TOGGLE: oc_q <= ~oc_q;
                    `COM_CLEAR: oc_q <= 1'b0;
                    `COM_SET: oc_q <= 1'b1;
                    `COM_NONE: oc_q <= oc_q;
                endcase
            end
        end
        else if (tick && ctrl_q.compare_out_mode[1])
        begin
            // mode 2: match sets when up-counting, clears when down-counting; fast pwm also sets at max
            if (match && !block_q && !CNT_WE_I)
                oc_q <= ~ctrl_q.compare_out_mode[0] ^ (dir_q == DIR_DOWN);
            else if (ctrl_q.waveform_mode_bits == `WGM_PWM_FAST
                    && cnt_q == MAXV)
                oc_q <= ~ctrl_q.compare_out_mode[0];
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            OVF_IRQ_O <= 1'b0;
            CMP_IRQ_O <= 1'b0;
            TOP_O <= 1'b0;
            BOTTOM_O <= 1'b0;
        end
        else
        begin
            OVF_IRQ_O <= flags_q.overflow_flag & mask_q[`FLAG_OVF];
            CMP_IRQ_O <= flags_q.compare_match_flag & mask_q[`FLAG_CMP];
            TOP_O <= at_top;
            BOTTOM_O <= at_bottom;
        end
    end

    assign COUNTER_VALUE_O = cnt_q;
    assign COMPARE_VALUE_REG_O = cmp_buf_q;
    assign TIMER_CONTROL_REG_O = ctrl_q;
    assign TIMER_FLAG_REG_O = flags_q;
    assign TIMER_MASK_REG_O = mask_q;
    assign COMPARE_OUTPUT_PIN_O = oc_q;
endmodule // tc8_timer

`default_nettype wire

// *** tc8_timer_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module tc8_timer_assertions
    import tc8_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [WIDTH-1:0] CNT_WDATA_I,
    input wire logic CNT_WE_I,
    input wire logic CTRL_WE_I,
    input wire logic [WIDTH-1:0] COUNTER_VALUE_O,
    input wire logic [WIDTH-1:0] COMPARE_VALUE_REG_O,
    input wire timer_control_t TIMER_CONTROL_REG_O,
    input wire timer_flags_t TIMER_FLAG_REG_O,
    input wire logic [1:0] TIMER_MASK_REG_O,
    input wire logic OVF_IRQ_O,
    input wire logic CMP_IRQ_O,
    input wire logic BOTTOM_O
);
    default clocking cb
        @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // ********************
    // quiet run conditions
    // ********************
    // held two cycles so a tick launched by an older setting has passed
    logic run;
    logic idle;
    assign run = TIMER_CONTROL_REG_O == timer_control_t'(8'h20)
        && !CNT_WE_I && !CTRL_WE_I;
    assign idle = TIMER_CONTROL_REG_O.clock_source_select == 3'h0
        && !CNT_WE_I && !CTRL_WE_I;

    reset_zero_a: assert property (disable iff (1'h0)
        !RESET_N_I |-> COUNTER_VALUE_O == '0 && TIMER_FLAG_REG_O == '0
        && TIMER_CONTROL_REG_O == '0)
        else $error("state not cleared in reset");
    stop_hold_a: assert property (idle [*2] |=>
        $stable(COUNTER_VALUE_O))
        else $error("counter moved while stopped");
    write_wins_a: assert property (CNT_WE_I |=>
        COUNTER_VALUE_O == $past(CNT_WDATA_I))
        else $error("counter write lost");
    count_up_a: assert property (run [*2] |=>
        COUNTER_VALUE_O == $past(COUNTER_VALUE_O) + 8'h01)
        else $error("normal mode did not count up");
    ovf_wrap_a: assert property (run [*2] ##0 COUNTER_VALUE_O == '1
        |=> TIMER_FLAG_REG_O.overflow_flag)
        else $error("overflow flag missed on wrap");
    match_flag_a: assert property (run [*2]
        ##0 COUNTER_VALUE_O == COMPARE_VALUE_REG_O
        |-> ##[1:2] TIMER_FLAG_REG_O.compare_match_flag)
        else $error("compare flag missed");
    ovf_irq_a: assert property (OVF_IRQ_O ==
        $past(TIMER_FLAG_REG_O.overflow_flag && TIMER_MASK_REG_O[0]))
        else $error("overflow request not gated by mask");
    cmp_irq_a: assert property (CMP_IRQ_O ==
        $past(TIMER_FLAG_REG_O.compare_match_flag && TIMER_MASK_REG_O[1]))
        else $error("compare request not gated by mask");
    bottom_ind_a: assert property (
        $past(RESET_N_I) && $past(RESET_N_I, 2)
        |-> BOTTOM_O == ($past(COUNTER_VALUE_O) == '0))
        else $error("bottom indication wrong");

    wrap_c: cover property (run ##1 TIMER_FLAG_REG_O.overflow_flag);
    cmp_irq_c: cover property (CMP_IRQ_O);
    ovf_irq_c: cover property (OVF_IRQ_O);
endmodule // tc8_timer_assertions

bind tc8_timer tc8_timer_assertions #(.WIDTH(WIDTH)) u_tc8_timer_assertions (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
    .CNT_WDATA_I(CNT_WDATA_I), .CNT_WE_I(CNT_WE_I), .CTRL_WE_I(CTRL_WE_I),
    .COUNTER_VALUE_O(COUNTER_VALUE_O),
    .COMPARE_VALUE_REG_O(COMPARE_VALUE_REG_O),
    .TIMER_CONTROL_REG_O(TIMER_CONTROL_REG_O),
    .TIMER_FLAG_REG_O(TIMER_FLAG_REG_O), .TIMER_MASK_REG_O(TIMER_MASK_REG_O),
    .OVF_IRQ_O(OVF_IRQ_O), .CMP_IRQ_O(CMP_IRQ_O), .BOTTOM_O(BOTTOM_O)
);
`default_nettype wire

// *** tc8_timer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tc8_timer_tb_top
    import tc8_pkg::*;
;
    localparam int DIV[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic clk = 1'h0;
    logic rst_n = 1'h1;
    logic osc = 1'h0;
    logic frc = 1'h0;
    logic oc;
    logic [4:0] we = 5'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] cnt, cmp, c, v, prev, mx;
    timer_control_t ctrl;
    timer_flags_t fl;
    logic [1:0] mask;
    logic oirq, cirq, top, bot;
    int num_errors = 0;
    int tests_run = 0;
    int i, z;

    always #50 clk = ~clk;

    // one shared data bus; flag clear rides on strobe 4 for both flags
    tc8_timer u_tc8_timer (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .CNT_WDATA_I(wd), .CNT_WE_I(we[0]), .CMP_WDATA_I(wd), .CMP_WE_I(we[1]),
        .CTRL_WDATA_I(timer_control_t'(wd)), .CTRL_WE_I(we[2]),
        .FORCE_CMP_I(frc), .MASK_WDATA_I(wd[1:0]), .MASK_WE_I(we[3]),
        .FLAG_CLR_I({2{we[4]}}), .CRYSTAL_OSC_IN_I(osc),
        .COUNTER_VALUE_O(cnt), .COMPARE_VALUE_REG_O(cmp),
        .TIMER_CONTROL_REG_O(ctrl), .TIMER_FLAG_REG_O(fl),
        .TIMER_MASK_REG_O(mask), .OVF_IRQ_O(oirq), .CMP_IRQ_O(cirq),
        .COMPARE_OUTPUT_PIN_O(oc), .TOP_O(top), .BOTTOM_O(bot)
    );

    // ********************
    // tasks
    // ********************
    task automatic chk(input string s, input logic [7:0] seen,
        input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask

    // ticks expected from a run of cycles at one prescaler ratio
    function automatic logic [7:0] ticks_in(input int cycles, input int div);
        return 8'(cycles / div);
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        we <= 5'(1 << sel);
        @(posedge clk);
        we <= 5'h00;
    endtask

    task automatic waitf(input int b);
        i = 0;
        while (fl[b] !== 1'h1 && i < 40)
        begin
            @(negedge clk);
            i++;
        end
        if (i == 40)
        begin
            num_errors++;
            results();
        end
    endtask

    // ********************
    // sequence
    // ********************
    initial
    begin
        void'($urandom(11));
        // a real falling edge, so the flops clear before the first clock
        rst_n <= 1'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk("cnt", cnt, 8'h00);
        chk("ctrl", ctrl, 8'h00);
        chk("flags", {4'h0, fl, mask}, 8'h00);
        $display("test reset done");
        v = 8'($urandom);
        c = 8'($urandom);
        wr(0, v);
        wr(1, c);
        wr(3, 8'h03);
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("cnt", cnt, v);
        chk("cmp", cmp, c);
        chk("mask", {6'h0, mask}, 8'h03);
        $display("test stopped done");
        wr(0, 8'hfc);
        wr(2, 8'h20);
        waitf(0);
        chk("wrap", cnt, 8'h00);
        @(negedge clk);
        chk("irq", {6'h0, oirq, bot}, 8'h03);
        wr(0, v);
        @(negedge clk);
        chk("wr", cnt, v);
        @(negedge clk);
        chk("inc", cnt, v + 8'h01);
        $display("test normal done");
        wr(2, 8'h00);
        wr(4, 8'h00);
        wr(0, c - 8'h05);
        wr(2, 8'h20);
        waitf(1);
        chk("match", cnt, c + 8'h01);
        @(negedge clk);
        chk("cirq", {7'h0, cirq}, 8'h01);
        wr(4, 8'h00);
        wr(0, c);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("block", {7'h0, fl[1]}, 8'h00);
        $display("test compare done");
        wr(2, 8'h00);
        c = {4'h0, 4'($urandom)} + 8'h04;
        wr(0, 8'h00);
        wr(1, c);
        wr(2, 8'h28);
        prev = 8'h00;
        mx = 8'h00;
        z = 0;
        repeat (40)
        begin
            @(negedge clk);
            chk("top", {7'h0, top}, {7'h0, prev == c});
            if (cnt > mx)
                mx = cnt;
            z += int'(cnt == 8'h00);
            prev = cnt;
        end
        chk("ctc", mx, c);
        chk("wraps", {7'h0, z > 1}, 8'h01);
        $display("test clear on match done");
        wr(2, 8'h00);
        wr(0, 8'hf8);
        wr(2, 8'h24);
        z = 0;
        repeat (14)
        begin
            @(negedge clk);
            if (prev == 8'hff)
                chk("down", cnt, 8'hfe);
            z += int'(prev == 8'hff);
            prev = cnt;
        end
        chk("peak", {7'h0, z == 1}, 8'h01);
        $display("test phase correct done");
        for (int k = 1; k < 8; k++)
        begin
            wr(2, 8'h00);
            wr(0, 8'h00);
            wr(2, {3'(k), 5'h00});
            repeat (3 * DIV[k]) @(posedge clk);
            @(negedge clk);
            chk("ticks", cnt, ticks_in(3 * DIV[k], DIV[k]));
        end
        $display("test prescaler done");
        wr(2, 8'h00);
        wr(0, 8'h00);
        wr(2, 8'h30);
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("xhold", cnt, 8'h00);
        repeat (8)
        begin
            repeat (4) @(posedge clk);
            osc <= 1'h1;
            repeat (4) @(posedge clk);
            osc <= 1'h0;
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("xtal", {7'h0, cnt inside {[8'h07:8'h08]}}, 8'h01);
        $display("test crystal done");
        wr(2, 8'h01);
        @(posedge clk);
        frc <= 1'h1;
        @(posedge clk);
        frc <= 1'h0;
        @(negedge clk);
        chk("force", {7'h0, oc}, 8'h01);
        wr(0, 8'h00);
        wr(2, 8'h2a);
        repeat (24) @(posedge clk);
        @(negedge clk);
        chk("ocpin", {7'h0, oc}, 8'h00);
        $display("test compare output done");
        results();
    end
endmodule // tc8_timer_tb_top
`default_nettype wire
